// ===== bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import tws_pkg::*;
   localparam int PROG = 1000;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic link_clk = 1'b0;
   logic wp_in = 1'b0;
   logic [2:0] sel = 3'h0;
   logic scl_m, sda_m, sda_out, sda_oe_n, standby, busy, sda_bus;
   logic [7:0] mem [256];
   logic [7:0] pend [int];
   int ptr;
   int errors = 0;
   int check_count = 0;
   assign sda_bus = sda_m & (sda_oe_n | sda_out);
   always #5 sys_clk = ~sys_clk;
   initial begin
      #3.1;
      forever #7.5 link_clk = ~link_clk;
   end
   tws_master_model mst (.sys_clk(sys_clk), .sda_bus(sda_bus), .scl(scl_m), .sda(sda_m));
   tws_eeprom_slave #(.PROG_CYCLES_P(PROG)) uut (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .link_clk(link_clk), .scl_in(scl_m),
      .sda_in(sda_bus), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_sel_bit0(sel[0]),
      .addr_sel_bit1(sel[1]), .addr_sel_bit2(sel[2]), .wp_in(wp_in), .standby(standby),
      .busy(busy)
   );
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   function automatic logic [7:0] dev(input logic rd, input logic [2:0] s);
      return {DEV_TYPE_CODE, s, rd};
   endfunction
   task automatic probe(input logic [7:0] a, input logic exp_nack);
      logic nack;
      mst.start();
      mst.wbyte(a, nack);
      mst.stop();
      check("probe", 8'(nack), 8'(exp_nack));
   endtask
   // Polls with the own address until the device answers again.
   task automatic finish_write(input logic prog);
      logic nack, first;
      int n;
      for (n = 0; n < 60 && busy !== 1'b1; n++) mst.tick(1);
      check("busy", 8'(busy), 8'(prog));
      if (busy !== prog) summarize();
      n = 0;
      nack = 1'b1;
      first = 1'b0;
      while (nack && n < 20) begin
         mst.start();
         mst.wbyte(dev(1'b0, sel), nack);
         mst.stop();
         if (n == 0) first = nack;
         n++;
      end
      check("first poll", 8'(first), 8'(prog));
      check("last poll", 8'(nack), 8'h0);
      check("standby", 8'(standby), 8'h1);
      if (nack) summarize();
      if (prog) foreach (pend[k]) mem[k] = pend[k];
      pend.delete();
   endtask
   // A count of zero leaves the bus open for a repeated start.
   task automatic write_bytes(input logic [7:0] a, input int cnt);
      logic nack;
      logic [7:0] d;
      mst.start();
      mst.wbyte(dev(1'b0, sel), nack);
      check("ack dev", 8'(nack), 8'h0);
      mst.wbyte(a, nack);
      check("ack word", 8'(nack), 8'h0);
      ptr = a;
      if (cnt == 0) return;
      for (int i = 0; i < cnt; i++) begin
         d = 8'($urandom);
         mst.wbyte(d, nack);
         check("ack data", 8'(nack), 8'h0);
         pend[ptr] = d;
         ptr = (ptr & 'hf0) | ((ptr + 1) & 'h0f);
      end
      mst.stop();
      finish_write(!wp_in);
   endtask
   task automatic read_bytes(input int cnt);
      logic nack;
      logic [7:0] d;
      mst.start();
      mst.wbyte(dev(1'b1, sel), nack);
      check("ack rd", 8'(nack), 8'h0);
      for (int i = 0; i < cnt; i++) begin
         mst.rbyte(i == cnt - 1, d);
         check("rdata", d, mem[ptr]);
         ptr = (ptr + 1) % MEM_BYTES;
      end
      mst.stop();
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic nack;
      void'($urandom(32'hf1e4));
      repeat (16) @(posedge sys_clk);
      #1;
      sys_rst = 1'b0;
      mst.tick(8);
      check("standby", 8'(standby), 8'h1);
      check("sda_oe_n", 8'(sda_oe_n), 8'h1);
      for (int i = 0; i < 8; i++) begin
         sel = 3'(i);
         mst.tick(8);
         probe(dev(1'b0, sel), 1'b0);
         probe(dev(1'b0, sel ^ 3'h5), 1'b1);
         probe({~DEV_TYPE_CODE, sel, 1'b0}, 1'b1);
      end
      $display("test select done");
      write_bytes(8'h0e, 18);
      read_bytes(1);
      $display("test page done");
      write_bytes(8'hff, 1);
      write_bytes(8'hff, 0);
      read_bytes(3);
      $display("test wrap done");
      write_bytes(8'h05, 1);
      wp_in = 1'b1;
      mst.tick(8);
      write_bytes(8'h05, 1);
      wp_in = 1'b0;
      mst.tick(8);
      write_bytes(8'h05, 0);
      read_bytes(1);
      $display("test protect done");
      mst.start();
      mst.wbyte(dev(1'b0, sel), nack);
      mst.bit_io(1'b0, nack);
      mst.bit_io(1'b1, nack);
      write_bytes(8'h08, 0);
      read_bytes(8);
      $display("test abort done");
      summarize();
   end
endmodule

// ===== bench/tws_eeprom_slave_asserts.sv
`timescale 1ns/1ps
module tws_eeprom_slave_asserts #(
   parameter int PROG_CYCLES_P = 50
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic link_clk,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe_n,
   input wire logic addr_sel_bit0,
   input wire logic addr_sel_bit1,
   input wire logic addr_sel_bit2,
   input wire logic wp_in,
   input wire logic standby,
   input wire logic busy
);
   int busy_cnt;
   always_ff @(posedge sys_clk) begin
      if (sys_rst || !busy) begin
         busy_cnt <= 0;
      end else begin
         busy_cnt <= busy_cnt + 1;
      end
   end
   default clocking cb @(posedge link_clk); endclocking
   default disable iff (sys_rst);
   property p_oe_low; $changed(sda_oe_n) |-> !scl_in; endproperty
   a_oe_low: assert property (p_oe_low) else $error("data moved with clock high");
   property p_quiet; busy |-> sda_oe_n; endproperty
   a_quiet: assert property (p_quiet) else $error("drive while busy");
   property p_awake; busy |-> !standby; endproperty
   a_awake: assert property (p_awake) else $error("standby while busy");
   property p_sleep; $fell(busy) |-> ##[0:2] standby; endproperty
   a_sleep: assert property (p_sleep) else $error("no standby after program");
   property p_rst; $fell(sys_rst) |-> standby && !busy && sda_oe_n; endproperty
   a_rst: assert property (p_rst) else $error("bad state after reset");
   // The write timer runs on sys_clk, so its length is counted there.
   property p_len;
      @(posedge sys_clk) $fell(busy) |-> busy_cnt >= PROG_CYCLES_P + 3 &&
         busy_cnt <= PROG_CYCLES_P + 9;
   endproperty
   a_len: assert property (p_len) else $error("program length wrong");
   property p_wp; $rose(busy) |-> !wp_in; endproperty
   a_wp: assert property (p_wp) else $error("program while protected");
   property p_stop; $rose(busy) |-> scl_in && sda_in; endproperty
   a_stop: assert property (p_stop) else $error("program not after stop");
   c_prog: cover property ($rose(busy));
   c_ack: cover property ($fell(sda_oe_n));
   c_wp: cover property (wp_in && $fell(sda_oe_n));
endmodule
bind tws_eeprom_slave tws_eeprom_slave_asserts #(.PROG_CYCLES_P(PROG_CYCLES_P)) u_chk (
   .sys_clk(sys_clk), .sys_rst(sys_rst), .link_clk(link_clk), .scl_in(scl_in),
   .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_sel_bit0(addr_sel_bit0),
   .addr_sel_bit1(addr_sel_bit1), .addr_sel_bit2(addr_sel_bit2), .wp_in(wp_in),
   .standby(standby), .busy(busy)
);

// ===== bench/tws_master_model.sv
`timescale 1ns/1ps
module tws_master_model #(
   parameter int HALF = 20
) (
   input wire logic sys_clk,
   input wire logic sda_bus,
   output logic scl,
   output logic sda
);
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // Also serves as repeated start and as abort of a broken transfer.
   task automatic start();
      sda = 1'b1;
      tick(HALF / 2);
      scl = 1'b1;
      tick(HALF);
      sda = 1'b0;
      tick(HALF);
      scl = 1'b0;
   endtask
   task automatic bit_io(input logic b, output logic r);
      tick(HALF / 2);
      sda = b;
      tick(HALF / 2);
      scl = 1'b1;
      tick(HALF / 2);
      r = sda_bus;
      tick(HALF / 2);
      scl = 1'b0;
   endtask
   task automatic wbyte(input logic [7:0] b, output logic nack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(b[i], r);
      end
      bit_io(1'b1, nack);
   endtask
   task automatic rbyte(input logic last, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, b[i]);
      end
      bit_io(last, r);
   endtask
   task automatic stop();
      tick(HALF / 2);
      sda = 1'b0;
      tick(HALF / 2);
      scl = 1'b1;
      tick(HALF);
      sda = 1'b1;
      tick(HALF);
   endtask
endmodule

// ===== design/tws_eeprom_slave.sv
`timescale 1ns/1ps
module tws_eeprom_slave #(
   parameter int PROG_CYCLES_P = tws_pkg::PROG_CYCLES
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic link_clk,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   input wire logic addr_sel_bit0,
   input wire logic addr_sel_bit1,
   input wire logic addr_sel_bit2,
   input wire logic wp_in,
   output logic standby,
   output logic busy
);
   import tws_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Link-domain reset and pin synchronisers.

   logic [1:0] lrst_sync_reg;
   logic lrst;
   logic [5:0] pin_s1_reg;
   logic [5:0] pin_s2_reg;
   logic scl_d_reg;
   logic sda_d_reg;
   logic scl_s;
   logic sda_s;
   logic wp_s;
   logic [2:0] sel_s;

   always_ff @(posedge link_clk) begin
      lrst_sync_reg <= {lrst_sync_reg[0], sys_rst};
   end
   assign lrst = lrst_sync_reg[1];

   // The first stage is read only by the second stage.
   always_ff @(posedge link_clk) begin
      pin_s1_reg <= {wp_in, addr_sel_bit2, addr_sel_bit1, addr_sel_bit0, sda_in, scl_in};
      pin_s2_reg <= pin_s1_reg;
   end
   assign scl_s = pin_s2_reg[0];
   assign sda_s = pin_s2_reg[1];
   assign sel_s = pin_s2_reg[4:2];
   assign wp_s = pin_s2_reg[5];

   always_ff @(posedge link_clk) begin
      if (lrst) begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         scl_d_reg <= scl_s;
         sda_d_reg <= sda_s;
      end
   end

   logic start_ev;
   logic stop_ev;
   logic scl_rise;
   logic scl_fall;

   assign start_ev = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
   assign stop_ev = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
   assign scl_rise = scl_s & ~scl_d_reg;
   assign scl_fall = ~scl_s & scl_d_reg;

   ////////////////////////////////////////////////////////////////////////
   // Address byte decode.

   function automatic logic addr_match(input logic [DATA_W-1:0] b, input logic [2:0] sel);
      addr_match = (b[TYPE_MSB:TYPE_LSB] == DEV_TYPE_CODE) && (b[SEL_MSB:SEL_LSB] == sel);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Protocol state machine.

   tws_state_t state_reg;
   logic [3:0] bit_cnt_reg;
   logic [DATA_W-1:0] shift_reg;
   logic [DATA_W-1:0] tx_reg;
   logic master_ack_reg;
   logic prog_pend_reg;
   logic [DATA_W-1:0] mem [MEM_BYTES];
   logic [ADDR_W-1:0] addr_ptr_reg;

   logic rx_state;
   logic byte_done;
   logic dev_ok;
   logic word_done;
   logic data_done;
   logic fetch;

   assign rx_state = (state_reg == TWS_DEVADDR) || (state_reg == TWS_WORDADDR) ||
                     (state_reg == TWS_WDATA);
   assign byte_done = rx_state && scl_fall && (bit_cnt_reg == BITS_PER_BYTE);
   // A poll during programming gets no acknowledge.
   assign dev_ok = addr_match(shift_reg, sel_s) && !prog_pend_reg;
   assign word_done = byte_done && (state_reg == TWS_WORDADDR);
   assign data_done = byte_done && (state_reg == TWS_WDATA);
   assign fetch = scl_fall && (((state_reg == TWS_ACK_DEV) && master_ack_reg) ||
                               ((state_reg == TWS_RACK) && master_ack_reg));

   always_ff @(posedge link_clk) begin
      if (lrst) begin
         state_reg <= TWS_IDLE;
         bit_cnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         tx_reg <= 8'h00;
         master_ack_reg <= 1'b0;
      end else if (start_ev) begin
         state_reg <= TWS_DEVADDR;
         bit_cnt_reg <= 4'h0;
      end else if (stop_ev) begin
         state_reg <= TWS_IDLE;
      end else begin
         if (rx_state && scl_rise && (bit_cnt_reg != BITS_PER_BYTE)) begin
            shift_reg <= {shift_reg[DATA_W-2:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
         end
         case (state_reg)
            TWS_IDLE: begin
               bit_cnt_reg <= 4'h0;
            end
            TWS_DEVADDR: begin
               if (byte_done) begin
                  if (dev_ok) begin
                     state_reg <= TWS_ACK_DEV;
                     // Read direction is remembered in the ack flag slot.
                     master_ack_reg <= (shift_reg[RW_BIT] == RW_READ);
                  end else begin
                     state_reg <= TWS_IDLE;
                  end
               end
            end
            TWS_ACK_DEV: begin
               if (scl_fall) begin
                  bit_cnt_reg <= 4'h0;
                  if (master_ack_reg) begin
                     state_reg <= TWS_RDATA;
                     tx_reg <= mem[addr_ptr_reg];
                  end else begin
                     state_reg <= TWS_WORDADDR;
                  end
               end
            end
            TWS_WORDADDR: begin
               if (byte_done) begin
                  state_reg <= TWS_ACK_WORD;
               end
            end
            TWS_ACK_WORD, TWS_ACK_WDATA: begin
               if (scl_fall) begin
                  state_reg <= TWS_WDATA;
                  bit_cnt_reg <= 4'h0;
               end
            end
            TWS_WDATA: begin
               if (byte_done) begin
                  state_reg <= TWS_ACK_WDATA;
               end
            end
            TWS_RDATA: begin
               if (scl_fall) begin
                  if (bit_cnt_reg == LAST_TX_BIT) begin
                     state_reg <= TWS_RACK;
                  end else begin
                     tx_reg <= {tx_reg[DATA_W-2:0], 1'b0};
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end
               end
            end
            TWS_RACK: begin
               if (scl_rise) begin
                  master_ack_reg <= ~sda_s;
               end
               if (scl_fall) begin
                  bit_cnt_reg <= 4'h0;
                  if (master_ack_reg) begin
                     state_reg <= TWS_RDATA;
                     tx_reg <= mem[addr_ptr_reg];
                  end else begin
                     state_reg <= TWS_IDLE;
                  end
               end
            end
            default: begin
               state_reg <= TWS_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Open-drain data output; the pin is only ever pulled low.

   logic sda_low_reg;

   always_ff @(posedge link_clk) begin
      if (lrst) begin
         sda_low_reg <= 1'b0;
      end else begin
         sda_low_reg <= (state_reg == TWS_ACK_DEV) || (state_reg == TWS_ACK_WORD) ||
                        (state_reg == TWS_ACK_WDATA) ||
                        ((state_reg == TWS_RDATA) && !tx_reg[DATA_W-1]);
      end
   end
   assign sda_out = 1'b0;
   assign sda_oe_n = ~sda_low_reg;

   ////////////////////////////////////////////////////////////////////////
   // Address counter and page buffer.

   logic [DATA_W-1:0] page_buf [PAGE_BYTES];
   logic [PAGE_BYTES-1:0] page_vld_reg;
   logic [PAGE_NUM_W-1:0] page_num_reg;

   always_ff @(posedge link_clk) begin
      if (lrst) begin
         addr_ptr_reg <= 8'h00;
         page_vld_reg <= 16'h0000;
         page_num_reg <= 4'h0;
      end else if (!start_ev && !stop_ev) begin
         if (word_done) begin
            addr_ptr_reg <= shift_reg;
            page_num_reg <= shift_reg[ADDR_W-1:PAGE_IDX_W];
            page_vld_reg <= 16'h0000;
         end else if (data_done) begin
            // Only the low nibble moves, so data wraps inside the page.
            page_buf[addr_ptr_reg[PAGE_IDX_W-1:0]] <= shift_reg;
            page_vld_reg[addr_ptr_reg[PAGE_IDX_W-1:0]] <= 1'b1;
            addr_ptr_reg[PAGE_IDX_W-1:0] <= addr_ptr_reg[PAGE_IDX_W-1:0] + 4'h1;
         end else if (fetch) begin
            addr_ptr_reg <= addr_ptr_reg + 8'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Programming request, completion and standby.

   logic req_tgl_reg;
   logic done_tgl_reg;
   logic [1:0] done_sync_reg;
   logic done_seen_reg;
   logic done_ev;
   logic standby_reg;
   logic write_stop;

   assign write_stop = stop_ev && (page_vld_reg != 16'h0000) &&
                       ((state_reg == TWS_WDATA) || (state_reg == TWS_ACK_WDATA));
   assign done_ev = done_sync_reg[1] ^ done_seen_reg;

   always_ff @(posedge link_clk) begin
      if (lrst) begin
         done_sync_reg <= 2'b00;
         done_seen_reg <= 1'b0;
      end else begin
         done_sync_reg <= {done_sync_reg[0], done_tgl_reg};
         done_seen_reg <= done_sync_reg[1];
      end
   end

   always_ff @(posedge link_clk) begin
      if (lrst) begin
         req_tgl_reg <= 1'b0;
         prog_pend_reg <= 1'b0;
      end else if (write_stop && !wp_s && !prog_pend_reg) begin
         req_tgl_reg <= ~req_tgl_reg;
         prog_pend_reg <= 1'b1;
      end else if (done_ev) begin
         prog_pend_reg <= 1'b0;
      end
   end

   // The written bytes of the page are committed in one step when programming ends.
   always_ff @(posedge link_clk) begin
      if (done_ev) begin
         for (int i = 0; i < PAGE_BYTES; i++) begin
            if (page_vld_reg[i]) begin
               mem[{page_num_reg, i[PAGE_IDX_W-1:0]}] <= page_buf[i];
            end
         end
      end
   end

   always_ff @(posedge link_clk) begin
      if (lrst) begin
         standby_reg <= 1'b1;
      end else if (done_ev) begin
         standby_reg <= 1'b1;
      end else if (start_ev) begin
         standby_reg <= 1'b0;
      end else if (stop_ev && !(write_stop && !wp_s && !prog_pend_reg)) begin
         standby_reg <= !prog_pend_reg;
      end
   end
   assign standby = standby_reg;
   assign busy = prog_pend_reg;

   ////////////////////////////////////////////////////////////////////////
   // System-domain write-cycle timer.

   logic [1:0] req_sync_reg;
   logic req_seen_reg;
   logic [PROG_CNT_W-1:0] prog_cnt_reg;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         req_sync_reg <= 2'b00;
         req_seen_reg <= 1'b0;
      end else begin
         req_sync_reg <= {req_sync_reg[0], req_tgl_reg};
         req_seen_reg <= req_sync_reg[1];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         prog_cnt_reg <= '0;
         done_tgl_reg <= 1'b0;
      end else if (req_sync_reg[1] ^ req_seen_reg) begin
         prog_cnt_reg <= PROG_CNT_W'(PROG_CYCLES_P);
      end else if (prog_cnt_reg != '0) begin
         prog_cnt_reg <= prog_cnt_reg - 1'b1;
         if (prog_cnt_reg == PROG_CNT_W'(1)) begin
            done_tgl_reg <= ~done_tgl_reg;
         end
      end
   end

endmodule

// ===== include/tws_pkg.sv
package tws_pkg;

   // Array geometry.
   localparam int MEM_BYTES = 256;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int PAGE_BYTES = 16;
   localparam int PAGE_IDX_W = 4;
   localparam int PAGE_NUM_W = ADDR_W - PAGE_IDX_W;

   // Address byte layout.
   localparam int TYPE_MSB = 7;
   localparam int TYPE_LSB = 4;
   localparam int SEL_MSB = 3;
   localparam int SEL_LSB = 1;
   localparam int RW_BIT = 0;
   localparam logic RW_READ = 1'b1;

   // Device type code; this value is arbitrary.
   localparam logic [3:0] DEV_TYPE_CODE = 4'h5;

   // Bits per byte on the wire and the bit count of the last transmitted bit.
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] LAST_TX_BIT = 4'h7;

   // Self-timed programming cycle.
   localparam int T_WR_MS = 5;
   localparam int SYS_CLK_KHZ = 100000;
   localparam int PROG_CYCLES = T_WR_MS * SYS_CLK_KHZ;
   localparam int PROG_CNT_W = 20;

   typedef enum logic [3:0] {
      TWS_IDLE,
      TWS_DEVADDR,
      TWS_ACK_DEV,
      TWS_WORDADDR,
      TWS_ACK_WORD,
      TWS_WDATA,
      TWS_ACK_WDATA,
      TWS_RDATA,
      TWS_RACK
   } tws_state_t;

endpackage
